// >>> src/dcg_pkg.sv
// Package for the converter clock, gain and auxiliary configuration bank.
// Assumes an AXI4-Lite master on aclk with 32-bit data.
package dcg_pkg;

	// ****************************************
	// Register indices; byte address is four times the index
	// ****************************************
	localparam logic [7:0] DCG_HIRES_AUX_MODE_CFG = 8'h24;
	localparam logic [7:0] DCG_DIVIDER_BUFFER_POWER_CFG = 8'h27;
	localparam logic [7:0] DCG_TIMING_REF_POLARITY_CFG = 8'h2b;
	localparam logic [7:0] DCG_INPUT_CLOCK_DIVIDER_CFG = 8'h32;
	localparam logic [7:0] DCG_GAIN_A_LOW = 8'h37;
	localparam logic [7:0] DCG_GAIN_A_HIGH = 8'h38;
	localparam logic [7:0] DCG_GAIN_B_LOW = 8'h39;
	localparam logic [7:0] DCG_GAIN_B_HIGH = 8'h3a;
	localparam logic [7:0] DCG_AUX_A_LOW = 8'h3b;
	localparam logic [7:0] DCG_AUX_A_HIGH = 8'h3c;
	localparam logic [7:0] DCG_AUX_B_LOW = 8'h3d;
	localparam logic [7:0] DCG_AUX_B_HIGH = 8'h3e;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] DCG_RST_HIRES = 8'hff;
	localparam logic [7:0] DCG_RST_DIVPWR = 8'h00;
	localparam logic [7:0] DCG_RST_TREF = 8'h88;
	localparam logic [7:0] DCG_RST_DIVCFG = 8'h88;
	localparam logic [7:0] DCG_RST_GAIN_LOW = 8'h20;
	localparam logic [7:0] DCG_RST_GAIN_HIGH = 8'h83;
	localparam logic [7:0] DCG_RST_AUX_LOW = 8'h00;
	localparam logic [7:0] DCG_RST_AUX_HIGH = 8'h82;

	// ****************************************
	// Field positions and write masks
	// ****************************************
	localparam int DCG_BIT_HIRES_BYPASS = 6;
	localparam int DCG_BIT_BUF2_PWR = 7;
	localparam int DCG_BIT_BUF1_PWR = 6;
	localparam int DCG_BIT_TREF_ASYNC = 7;
	localparam int DCG_BIT_WEST_INV = 6;
	localparam int DCG_BIT_EAST_INV = 5;
	localparam int DCG_BIT_DIV_RATIO_LO = 6;
	localparam int DCG_BIT_DIV_RESET = 6;
	localparam int DCG_BIT_FREQ_MODE = 4;
	localparam int DCG_BIT_DIV_BYPASS = 3;
	localparam int DCG_BIT_PHASE_LO = 0;
	localparam int DCG_BIT_POWER = 7;
	localparam int DCG_BIT_X2 = 2;
	localparam int DCG_BIT_CODE_HI_LO = 0;
	localparam logic [7:0] DCG_MASK_DIVPWR = 8'hc0;
	localparam logic [7:0] DCG_MASK_TREF = 8'hef;
	localparam logic [7:0] DCG_MASK_GAIN_HIGH = 8'h87;
	localparam logic [7:0] DCG_MASK_AUX_HIGH = 8'h83;
	localparam logic [7:0] DCG_MASK_ALL = 8'hff;

	// ****************************************
	// Bus answers
	// ****************************************
	localparam logic [1:0] DCG_RESP_OKAY = 2'b00;
	localparam logic [1:0] DCG_RESP_SLVERR = 2'b10;

	typedef enum logic [1:0] {
		DCG_DIV_2,
		DCG_DIV_4,
		DCG_DIV_6,
		DCG_DIV_8
	} dcg_ratio_t;

endpackage

// >>> src/dcg_config_bank.sv
// Configuration register bank: auxiliary mode, divider buffers, timing-reference
// polarity, input clock divider, analog gain and auxiliary converter codes.
// Assumes an AXI4-Lite master on aclk; outputs other than the one-cycle input_divider_reset pulse are static configuration levels.
//
// Contract
// R1: High-resolution register bit 6 zero enables, one bypasses high-resolution aux mode.
// R2: Buffer power bit 7 powers divider buffer two, bit 6 buffer one.
// R3: Timing-reference bits 6 and 5 invert west and east inputs when set.
// R4: Software keeps timing-reference bit 7 zero and bits 3..0 at 1000.
// R5: Divider ratio bits 7..6 select clock input divided by 2, 4, 6, 8.
// R6: Writing one to divider reset bit resets dividers; zero does nothing.
// R7: Divider bit 3 set bypasses dividers and phase; clock equals input.
// R8: Phase bits 2..0 offset converter clock by code times half input period.
// R9: Channel A gain is ten bits: low byte 0x37, top two in 0x38.
// R10: Channel B gain is ten bits: low byte 0x39, top two in 0x3a.
// R11: Channel A gain upper bit 7 switches channel A gain circuit on.
// R12: Channel B gain upper bit 7 switches channel B gain circuit on.
// R13: Gain upper bit 2 selects doubled output current range per channel.
// R14: Channel A auxiliary code is ten bits: low 0x3b, top two in 0x3c.
// R15: Channel A auxiliary upper bit 7 turns channel A auxiliary converter on.
// R16: Channel B auxiliary code is ten bits at 0x3d/0x3e, power bit 7.
`timescale 1ns/1ps

module dcg_config_bank #(
	parameter int ADDR_W = 8,
	parameter int CODE_W = 10
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Auxiliary mode and divider buffers
	output logic hires_aux_bypass,
	output logic divider_buffer2_power,
	output logic divider_buffer1_power,
	// Timing reference
	output logic west_timing_ref_invert,
	output logic east_timing_ref_invert,
	// Input clock divider
	output dcg_pkg::dcg_ratio_t input_divide_ratio,
	output logic input_divider_reset,
	output logic divider_frequency_mode,
	output logic input_divider_bypass,
	output logic [2:0] input_divider_phase,
	// Analog gain
	output logic [CODE_W-1:0] gain_code_a,
	output logic [CODE_W-1:0] gain_code_b,
	output logic gain_power_a,
	output logic gain_power_b,
	output logic gain_range_double_a,
	output logic gain_range_double_b,
	// Auxiliary converters
	output logic [CODE_W-1:0] aux_code_a,
	output logic [CODE_W-1:0] aux_code_b,
	output logic aux_power_a,
	output logic aux_power_b
);
	import dcg_pkg::*;

	// ****************************************
	// Storage
	// ****************************************
	logic [7:0] hires_q, divpwr_q, tref_q, divcfg_q;
	logic [7:0] gal_q, gah_q, gbl_q, gbh_q, aal_q, aah_q, abl_q, abh_q;
	logic [ADDR_W-1:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic aw_have_q, w_have_q;
	logic wr_go;
	logic wr_hit;
	logic [7:0] wr_byte;
	logic rd_hit;
	logic [7:0] rd_byte;

	// Byte lane of a word-aligned register sits in the low lane
	function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] mask);
		merge = (wdata_q[7:0] & mask) | (old & ~mask);
	endfunction

	// ****************************************
	// Write channel
	// ****************************************
	// Offsets not multiples of four: each register index is kept and byte address is 4x
	function automatic logic [ADDR_W-1:0] baddr(input logic [7:0] idx);
		baddr = ADDR_W'({idx, 2'b00});
	endfunction

	assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
	assign wr_byte = wdata_q[7:0];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			awaddr_q <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_have_q <= 1'b1;
			awaddr_q <= s_axi_awaddr;
		end else if (wr_go) begin
			aw_have_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_have_q <= 1'b0;
			wdata_q <= '0;
			wstrb_q <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_have_q <= 1'b1;
			wdata_q <= s_axi_wdata;
			wstrb_q <= s_axi_wstrb;
		end else if (wr_go) begin
			w_have_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
		end else begin
			s_axi_awready <= !(aw_have_q || (s_axi_awvalid && s_axi_awready)) || wr_go;
			s_axi_wready <= !(w_have_q || (s_axi_wvalid && s_axi_wready)) || wr_go;
		end
	end

	// Address hit for write
	always_comb begin
		wr_hit = 1'b1;
		if (awaddr_q == baddr(DCG_HIRES_AUX_MODE_CFG)) begin
			wr_hit = 1'b1;
		end else if (awaddr_q == baddr(DCG_DIVIDER_BUFFER_POWER_CFG)) begin
			wr_hit = 1'b1;
		end else if (awaddr_q == baddr(DCG_TIMING_REF_POLARITY_CFG)) begin
			wr_hit = 1'b1;
		end else if (awaddr_q == baddr(DCG_INPUT_CLOCK_DIVIDER_CFG)) begin
			wr_hit = 1'b1;
		end else if (awaddr_q[ADDR_W-1:2] >= DCG_GAIN_A_LOW[ADDR_W-3:0]
				&& awaddr_q[ADDR_W-1:2] <= DCG_AUX_B_HIGH[ADDR_W-3:0]
				&& awaddr_q[1:0] == 2'b00) begin
			wr_hit = 1'b1;
		end else begin
			wr_hit = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= DCG_RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_hit ? DCG_RESP_OKAY : DCG_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ****************************************
	// Configuration registers
	// ****************************************
	logic wr_lane;
	assign wr_lane = wr_go && wstrb_q[0];

	// Storage for the clock-side registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hires_q <= DCG_RST_HIRES;
			divpwr_q <= DCG_RST_DIVPWR;
			tref_q <= DCG_RST_TREF;
			divcfg_q <= DCG_RST_DIVCFG;
		end else if (wr_lane) begin
			// R1: bypass bit stored
			if (awaddr_q == baddr(DCG_HIRES_AUX_MODE_CFG)) begin
				hires_q <= merge(hires_q, DCG_MASK_ALL);
			end
			// R2: buffer power bits
			if (awaddr_q == baddr(DCG_DIVIDER_BUFFER_POWER_CFG)) begin
				divpwr_q <= merge(divpwr_q, DCG_MASK_DIVPWR);
			end
			// R3: polarity bits; unused bit 4 stays zero
			if (awaddr_q == baddr(DCG_TIMING_REF_POLARITY_CFG)) begin
				tref_q <= merge(tref_q, DCG_MASK_TREF);
			end
			if (awaddr_q == baddr(DCG_INPUT_CLOCK_DIVIDER_CFG)) begin
				divcfg_q <= merge(divcfg_q, DCG_MASK_ALL);
			end
		end
	end

	// R9: R10: R14: R16: ten-bit code storage
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gal_q <= DCG_RST_GAIN_LOW;
			gah_q <= DCG_RST_GAIN_HIGH;
			gbl_q <= DCG_RST_GAIN_LOW;
			gbh_q <= DCG_RST_GAIN_HIGH;
			aal_q <= DCG_RST_AUX_LOW;
			aah_q <= DCG_RST_AUX_HIGH;
			abl_q <= DCG_RST_AUX_LOW;
			abh_q <= DCG_RST_AUX_HIGH;
		end else if (wr_lane) begin
			if (awaddr_q == baddr(DCG_GAIN_A_LOW)) begin
				gal_q <= wr_byte;
			end
			if (awaddr_q == baddr(DCG_GAIN_A_HIGH)) begin
				gah_q <= merge(gah_q, DCG_MASK_GAIN_HIGH);
			end
			if (awaddr_q == baddr(DCG_GAIN_B_LOW)) begin
				gbl_q <= wr_byte;
			end
			if (awaddr_q == baddr(DCG_GAIN_B_HIGH)) begin
				gbh_q <= merge(gbh_q, DCG_MASK_GAIN_HIGH);
			end
			if (awaddr_q == baddr(DCG_AUX_A_LOW)) begin
				aal_q <= wr_byte;
			end
			if (awaddr_q == baddr(DCG_AUX_A_HIGH)) begin
				aah_q <= merge(aah_q, DCG_MASK_AUX_HIGH);
			end
			if (awaddr_q == baddr(DCG_AUX_B_LOW)) begin
				abl_q <= wr_byte;
			end
			if (awaddr_q == baddr(DCG_AUX_B_HIGH)) begin
				abh_q <= merge(abh_q, DCG_MASK_AUX_HIGH);
			end
		end
	end

	// ****************************************
	// Read channel
	// ****************************************
	always_comb begin
		rd_hit = 1'b1;
		rd_byte = 8'h00;
		if (s_axi_araddr == baddr(DCG_HIRES_AUX_MODE_CFG)) begin
			rd_byte = hires_q;
		end else if (s_axi_araddr == baddr(DCG_DIVIDER_BUFFER_POWER_CFG)) begin
			rd_byte = divpwr_q;
		end else if (s_axi_araddr == baddr(DCG_TIMING_REF_POLARITY_CFG)) begin
			rd_byte = tref_q;
		end else if (s_axi_araddr == baddr(DCG_INPUT_CLOCK_DIVIDER_CFG)) begin
			rd_byte = divcfg_q;
		end else if (s_axi_araddr == baddr(DCG_GAIN_A_LOW)) begin
			rd_byte = gal_q;
		end else if (s_axi_araddr == baddr(DCG_GAIN_A_HIGH)) begin
			rd_byte = gah_q;
		end else if (s_axi_araddr == baddr(DCG_GAIN_B_LOW)) begin
			rd_byte = gbl_q;
		end else if (s_axi_araddr == baddr(DCG_GAIN_B_HIGH)) begin
			rd_byte = gbh_q;
		end else if (s_axi_araddr == baddr(DCG_AUX_A_LOW)) begin
			rd_byte = aal_q;
		end else if (s_axi_araddr == baddr(DCG_AUX_A_HIGH)) begin
			rd_byte = aah_q;
		end else if (s_axi_araddr == baddr(DCG_AUX_B_LOW)) begin
			rd_byte = abl_q;
		end else if (s_axi_araddr == baddr(DCG_AUX_B_HIGH)) begin
			rd_byte = abh_q;
		end else begin
			rd_hit = 1'b0;
		end
	end

	// One read outstanding: arready drops while the answer waits
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= DCG_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {24'h00_0000, rd_byte};
			s_axi_rresp <= rd_hit ? DCG_RESP_OKAY : DCG_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ****************************************
	// Divider reset pulse
	// ****************************************
	// R6: one written to bit 6 resets dividers for one cycle; zero does nothing
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			input_divider_reset <= 1'b0;
		end else begin
			input_divider_reset <= wr_lane
				&& awaddr_q == baddr(DCG_INPUT_CLOCK_DIVIDER_CFG)
				&& wr_byte[DCG_BIT_DIV_RESET];
		end
	end

	// ****************************************
	// Configuration outputs
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hires_aux_bypass <= DCG_RST_HIRES[DCG_BIT_HIRES_BYPASS];
			divider_buffer2_power <= DCG_RST_DIVPWR[DCG_BIT_BUF2_PWR];
			divider_buffer1_power <= DCG_RST_DIVPWR[DCG_BIT_BUF1_PWR];
			west_timing_ref_invert <= DCG_RST_TREF[DCG_BIT_WEST_INV];
			east_timing_ref_invert <= DCG_RST_TREF[DCG_BIT_EAST_INV];
			input_divide_ratio <= dcg_ratio_t'(DCG_RST_DIVCFG[DCG_BIT_DIV_RATIO_LO +: 2]);
			divider_frequency_mode <= DCG_RST_DIVCFG[DCG_BIT_FREQ_MODE];
			input_divider_bypass <= DCG_RST_DIVCFG[DCG_BIT_DIV_BYPASS];
			input_divider_phase <= DCG_RST_DIVCFG[DCG_BIT_PHASE_LO +: 3];
		end else begin
			// R1: zero enables, one bypasses
			hires_aux_bypass <= hires_q[DCG_BIT_HIRES_BYPASS];
			// R2: buffer power levels
			divider_buffer2_power <= divpwr_q[DCG_BIT_BUF2_PWR];
			divider_buffer1_power <= divpwr_q[DCG_BIT_BUF1_PWR];
			// R3: polarity inversion
			west_timing_ref_invert <= tref_q[DCG_BIT_WEST_INV];
			east_timing_ref_invert <= tref_q[DCG_BIT_EAST_INV];
			// R5: ratio code selects 2, 4, 6 or 8
			input_divide_ratio <= dcg_ratio_t'(divcfg_q[DCG_BIT_DIV_RATIO_LO +: 2]);
			divider_frequency_mode <= divcfg_q[DCG_BIT_FREQ_MODE];
			// R7: bypass forces the phase output to zero; ratio passes unchanged
			input_divider_bypass <= divcfg_q[DCG_BIT_DIV_BYPASS];
			// R8: phase offset in half input periods; forced to zero under bypass
			input_divider_phase <= divcfg_q[DCG_BIT_DIV_BYPASS] ? 3'b000
				: divcfg_q[DCG_BIT_PHASE_LO +: 3];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gain_code_a <= CODE_W'({DCG_RST_GAIN_HIGH[1:0], DCG_RST_GAIN_LOW});
			gain_code_b <= CODE_W'({DCG_RST_GAIN_HIGH[1:0], DCG_RST_GAIN_LOW});
			gain_power_a <= DCG_RST_GAIN_HIGH[DCG_BIT_POWER];
			gain_power_b <= DCG_RST_GAIN_HIGH[DCG_BIT_POWER];
			gain_range_double_a <= DCG_RST_GAIN_HIGH[DCG_BIT_X2];
			gain_range_double_b <= DCG_RST_GAIN_HIGH[DCG_BIT_X2];
			aux_code_a <= CODE_W'({DCG_RST_AUX_HIGH[1:0], DCG_RST_AUX_LOW});
			aux_code_b <= CODE_W'({DCG_RST_AUX_HIGH[1:0], DCG_RST_AUX_LOW});
			aux_power_a <= DCG_RST_AUX_HIGH[DCG_BIT_POWER];
			aux_power_b <= DCG_RST_AUX_HIGH[DCG_BIT_POWER];
		end else begin
			// R9: R10: gain codes joined from upper and lower bytes
			gain_code_a <= CODE_W'({gah_q[DCG_BIT_CODE_HI_LO +: 2], gal_q});
			gain_code_b <= CODE_W'({gbh_q[DCG_BIT_CODE_HI_LO +: 2], gbl_q});
			// R11: R12: gain circuit power
			gain_power_a <= gah_q[DCG_BIT_POWER];
			gain_power_b <= gbh_q[DCG_BIT_POWER];
			// R13: doubled current range
			gain_range_double_a <= gah_q[DCG_BIT_X2];
			gain_range_double_b <= gbh_q[DCG_BIT_X2];
			// R14: R16: auxiliary codes
			aux_code_a <= CODE_W'({aah_q[DCG_BIT_CODE_HI_LO +: 2], aal_q});
			aux_code_b <= CODE_W'({abh_q[DCG_BIT_CODE_HI_LO +: 2], abl_q});
			// R15: R16: auxiliary power
			aux_power_a <= aah_q[DCG_BIT_POWER];
			aux_power_b <= abh_q[DCG_BIT_POWER];
		end
	end

endmodule

// >>> dv/dcg_config_bank_props.sv
// Checker for the configuration bank: bus handshakes, answer timing and output levels.
// Assumes it is bound into dcg_config_bank and sees only that module's ports.
`timescale 1ns/1ps

module dcg_config_bank_props #(
	parameter int ADDR_W = 8,
	parameter int CODE_W = 10
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Configuration outputs
	input wire logic hires_aux_bypass,
	input wire logic divider_buffer1_power,
	input wire logic input_divider_reset,
	input wire logic input_divider_bypass,
	input wire logic [2:0] input_divider_phase,
	input wire logic [CODE_W-1:0] gain_code_a,
	input wire logic [CODE_W-1:0] aux_code_b,
	input wire logic aux_power_a
);
	import dcg_pkg::*;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence wr_busy;
		!s_axi_awready && !s_axi_wready;
	endsequence

	wr_answer_a: assert property (wr_taken |=> wr_busy ##1 s_axi_bvalid)
		else $error("write answer not two cycles after acceptance");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer not one cycle after acceptance");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before bready");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before rready");
	rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
		else $error("read data upper bits not zero");
	reset_pulse_a: assert property (input_divider_reset |=> !input_divider_reset)
		else $error("divider reset longer than one cycle");
	phase_bypass_a: assert property (input_divider_bypass |-> input_divider_phase == 3'h0)
		else $error("phase offset shown while divider bypassed");
	config_stable_a: assert property (!s_axi_bvalid && !$past(s_axi_bvalid)
		&& !$past(s_axi_bvalid, 2) |-> $stable(gain_code_a) && $stable(aux_code_b))
		else $error("configuration changed without a write");
	reset_value_a: assert property (@(posedge aclk) disable iff (1'b0)
		!aresetn ##1 !aresetn |-> hires_aux_bypass && !divider_buffer1_power && aux_power_a
		&& gain_code_a == 10'h320 && aux_code_b == 10'h200 && !s_axi_bvalid && !s_axi_rvalid)
		else $error("reset values wrong");
endmodule

bind dcg_config_bank dcg_config_bank_props #(.ADDR_W(ADDR_W), .CODE_W(CODE_W)) u_props (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .hires_aux_bypass(hires_aux_bypass),
	.divider_buffer1_power(divider_buffer1_power), .input_divider_reset(input_divider_reset),
	.input_divider_bypass(input_divider_bypass), .input_divider_phase(input_divider_phase),
	.gain_code_a(gain_code_a), .aux_code_b(aux_code_b), .aux_power_a(aux_power_a));

// >>> dv/tb_top.sv
// Self-checking bench for the configuration bank: reset values, register rows, bus errors.
// Assumes byte address is four times the register index and a 200 MHz aclk.
`timescale 1ns/1ps

module tb_top;
	import dcg_pkg::*;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [2:0] s_axi_awprot, s_axi_arprot, input_divider_phase;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic hires_aux_bypass, divider_buffer2_power, divider_buffer1_power, input_divider_reset;
	logic west_timing_ref_invert, east_timing_ref_invert, divider_frequency_mode;
	logic input_divider_bypass, gain_power_a, gain_power_b, aux_power_a, aux_power_b;
	logic gain_range_double_a, gain_range_double_b;
	logic [9:0] gain_code_a, gain_code_b, aux_code_a, aux_code_b;
	logic [31:0] d;
	dcg_ratio_t input_divide_ratio;
	logic [57:0] outs;
	logic [7:0] ridx [12], rrst [12], sh [12];
	logic [19:0] rows [22];
	int mismatches, checks, pcount, exp_p, k;

	assign outs = {hires_aux_bypass, divider_buffer2_power, divider_buffer1_power,
		west_timing_ref_invert, east_timing_ref_invert, input_divide_ratio, divider_frequency_mode,
		input_divider_bypass, input_divider_phase, gain_code_a, gain_power_a, gain_range_double_a,
		gain_code_b, gain_power_b, gain_range_double_b, aux_code_a, aux_power_a, aux_code_b,
		aux_power_b};

	dcg_config_bank dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awprot(s_axi_awprot), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(s_axi_arprot),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.hires_aux_bypass(hires_aux_bypass), .divider_buffer2_power(divider_buffer2_power),
		.divider_buffer1_power(divider_buffer1_power),
		.west_timing_ref_invert(west_timing_ref_invert),
		.east_timing_ref_invert(east_timing_ref_invert), .input_divide_ratio(input_divide_ratio),
		.input_divider_reset(input_divider_reset), .divider_frequency_mode(divider_frequency_mode),
		.input_divider_bypass(input_divider_bypass), .input_divider_phase(input_divider_phase),
		.gain_code_a(gain_code_a), .gain_code_b(gain_code_b), .gain_power_a(gain_power_a),
		.gain_power_b(gain_power_b), .gain_range_double_a(gain_range_double_a),
		.gain_range_double_b(gain_range_double_b), .aux_code_a(aux_code_a),
		.aux_code_b(aux_code_b), .aux_power_a(aux_power_a), .aux_power_b(aux_power_b));

	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end

	// Counts divider reset pulses seen at the output
	always @(posedge aclk) begin
		if (input_divider_reset === 1'b1)
			pcount <= pcount + 1;
	end

	initial begin
		#50000;
		mismatches++;
		end_sim();
	end

	// ****************************************
	// Tasks
	// ****************************************
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string m);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH at %0t: %s seen %0h expected %0h", $time, m, seen, exp);
		end
	endtask

	function automatic logic [7:0] ba(input logic [7:0] i);
		return i << 2;
	endfunction

	function automatic logic [57:0] expect_out();
		logic [2:0] ph;
		ph = sh[3][3] ? 3'h0 : sh[3][2:0];
		return {sh[0][6], sh[1][7], sh[1][6], sh[2][6], sh[2][5], sh[3][7:6], sh[3][4], sh[3][3],
			ph, sh[5][1:0], sh[4], sh[5][7], sh[5][2], sh[7][1:0], sh[6], sh[7][7], sh[7][2],
			sh[9][1:0], sh[8], sh[9][7], sh[11][1:0], sh[10], sh[11][7]};
	endfunction

	// Address and data offered together; bready comes late so bvalid must wait
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] wd32, input logic [3:0] s,
		output logic [1:0] rs);
		int n;
		bit done;
		n = 0;
		done = 0;
		rs = 2'h3;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= wd32;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!done && n < 100) begin
			@(posedge aclk);
			n++;
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (n == 5)
				s_axi_bready <= 1'b1;
			if (s_axi_bvalid && s_axi_bready) begin
				rs = s_axi_bresp;
				done = 1;
				s_axi_bready <= 1'b0;
			end
		end
		chk(done, 1, "write answer");
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] rd, output logic [1:0] rs);
		int n;
		bit done;
		n = 0;
		done = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		while (!done && n < 100) begin
			@(posedge aclk);
			n++;
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (n == 3)
				s_axi_rready <= 1'b1;
			if (s_axi_rvalid && s_axi_rready) begin
				rd = s_axi_rdata;
				rs = s_axi_rresp;
				done = 1;
				s_axi_rready <= 1'b0;
			end
		end
		chk(done, 1, "read answer");
	endtask

	task automatic check_all();
		logic [31:0] rd;
		logic [1:0] rs;
		chk(outs, expect_out(), "outputs");
		for (int j = 0; j < 12; j++) begin
			axi_rd(ba(ridx[j]), rd, rs);
			chk({rs, rd}, {DCG_RESP_OKAY, 24'h00_0000, sh[j]}, "readback");
		end
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		ridx = '{DCG_HIRES_AUX_MODE_CFG, DCG_DIVIDER_BUFFER_POWER_CFG, DCG_TIMING_REF_POLARITY_CFG,
			DCG_INPUT_CLOCK_DIVIDER_CFG, DCG_GAIN_A_LOW, DCG_GAIN_A_HIGH, DCG_GAIN_B_LOW,
			DCG_GAIN_B_HIGH, DCG_AUX_A_LOW, DCG_AUX_A_HIGH, DCG_AUX_B_LOW, DCG_AUX_B_HIGH};
		rrst = '{8'hff, 8'h00, 8'h88, 8'h88, 8'h20, 8'h83, 8'h20, 8'h83, 8'h00, 8'h82, 8'h00, 8'h82};
		// Row: position in ridx, byte written, byte that should be stored and read back
		// written reserved bits dropped
		rows = '{20'h0_bfbf, 20'h0_4040, 20'h1_ffc0, 20'h1_8080, 20'h1_4040, 20'h2_4848,
			20'h2_2828, 20'h2_7868, 20'h3_0505, 20'h3_4747, 20'h3_9090, 20'h3_cfcf,
			20'h3_0000, 20'h4_5555, 20'h5_8686, 20'h6_aaaa, 20'h7_7b03, 20'h5_0101,
			20'h8_3c3c, 20'h9_ff83, 20'ha_c3c3, 20'hb_0101};
		sh = rrst;
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata, s_axi_wstrb} = '0;
		{mismatches, checks, pcount, exp_p} = '0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		check_all();
		for (int i = 0; i < 22; i++) begin
			k = rows[i][19:16];
			axi_wr(ba(ridx[k]), 32'(rows[i][15:8]), 4'hf, r);
			sh[k] = rows[i][7:0];
			if (k == 3 && rows[i][14])
				exp_p++;
			repeat (2) @(posedge aclk);
			chk(r, DCG_RESP_OKAY, "row response");
			chk(outs, expect_out(), "row outputs");
			chk(pcount, exp_p, "divider reset pulses");
			axi_rd(ba(ridx[k]), d, r);
			chk(d, 32'(sh[k]), "row readback");
		end
		// Strobe off stores nothing; unmapped and misaligned places are refused
		axi_wr(ba(ridx[4]), 32'h0000_00ff, 4'h0, r);
		chk(r, DCG_RESP_OKAY, "strobe off response");
		axi_wr(8'h94, 32'h0000_00ff, 4'hf, r);
		chk(r, DCG_RESP_SLVERR, "unmapped write");
		axi_wr(ba(ridx[5]) + 8'h01, 32'h0000_0000, 4'hf, r);
		chk(r, DCG_RESP_SLVERR, "misaligned write");
		axi_rd(8'h94, d, r);
		chk({r, d}, {DCG_RESP_SLVERR, 32'h0000_0000}, "unmapped read");
		axi_wr(ba(ridx[6]), 32'h0000_0011, 4'hf, r);
		sh[6] = 8'h11;
		axi_wr(ba(ridx[10]), 32'h0000_0022, 4'hf, r);
		sh[10] = 8'h22;
		repeat (2) @(posedge aclk);
		check_all();
		// Reset in mid-run brings back every reset value
		aresetn <= 1'b0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		sh = rrst;
		@(posedge aclk);
		check_all();
		end_sim();
	end
endmodule
